/* File: design/sbg_pkg.sv */
/*
  sbg_pkg: constants shared by the baud generator and its prescaler.
  assumes: one clock domain, APB register access with 8-bit word-aligned offsets.
*/
package sbg_pkg;
    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_BAUD = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FDV = 8'h08;
    localparam logic [7:0] ADDR_TXD = 8'h0C;
    localparam logic [7:0] ADDR_RXD = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // =========================================================
    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RSEL = 1;
    localparam int CTRL_FDE = 2;
    localparam int CTRL_SYNC = 3;
    localparam int CTRL_RXEN = 4;
    // =========================================================
    // widths and reset values
    localparam int TIMER_W = 13;
    localparam int FDV_W = 9;
    localparam int BYTE_W = 8;
    localparam logic [TIMER_W-1:0] TIMER_RST = 13'h0000;
    localparam logic [FDV_W-1:0] FDV_RST = 9'h000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    // =========================================================
    // timing counts
    localparam logic [1:0] PRE_DIV2_LAST = 2'h1;
    localparam logic [1:0] PRE_DIV3_LAST = 2'h2;
    localparam logic [3:0] SMP_LAST = 4'hF;
    localparam logic [3:0] SMP_FIRST_VOTE = 4'h6;
    localparam logic [3:0] SMP_LAST_VOTE = 4'h8;
    localparam logic [1:0] Q_BEFORE_RISE = 2'h1;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // =========================================================
    // synchronous shift engine states (gray along idle-shift-gap)
    typedef enum logic [1:0] {
        SBG_IDLE = 2'b00,
        SBG_SHIFT = 2'b01,
        SBG_GAP = 2'b11
    } sbg_state_t;
endpackage

/* File: design/sbg_tick_if.sv */
/*
  sbg_tick_if: prescaler configuration and its output tick.
  assumes: both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sbg_tick_if;
    logic run;
    logic rateSelect;
    logic fracEnable;
    logic [sbg_pkg::FDV_W-1:0] fracValue;
    logic divTick;
    modport prescaler (input run, input rateSelect, input fracEnable, input fracValue, output divTick);
    modport core (output run, output rateSelect, output fracEnable, output fracValue, input divTick);
endinterface
`default_nettype wire

/* File: design/sbg_prescaler.sv */
/*
  sbg_prescaler: fixed /2 or /3 divider, or n/512 fractional divider.
  assumes: configuration changes only while the run bit is clear.
*/
`timescale 1ns/1ps
`default_nettype none
module sbg_prescaler (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // configuration and tick
    sbg_tick_if.prescaler tick
);
    logic [1:0] fixCnt_ff;
    logic [sbg_pkg::FDV_W-1:0] fracAcc_ff;
    logic [sbg_pkg::FDV_W:0] fracSum;
    logic [1:0] fixLast;

    assign fracSum = {1'b0, fracAcc_ff} + {1'b0, tick.fracValue};
    assign fixLast = tick.rateSelect ? sbg_pkg::PRE_DIV3_LAST : sbg_pkg::PRE_DIV2_LAST;

    // =========================================================
    // divider
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fixCnt_ff <= 2'h0;
            fracAcc_ff <= sbg_pkg::FDV_RST;
            tick.divTick <= 1'b0;
        end else if (!tick.run) begin
            tick.divTick <= 1'b0;
        end else if (tick.fracEnable) begin
            fracAcc_ff <= fracSum[sbg_pkg::FDV_W-1:0];
            tick.divTick <= fracSum[sbg_pkg::FDV_W] || (tick.fracValue == sbg_pkg::FDV_RST);
        end else begin
            tick.divTick <= (fixCnt_ff == fixLast);
            fixCnt_ff <= (fixCnt_ff == fixLast) ? 2'h0 : fixCnt_ff + 2'h1;
        end
    end
endmodule // sbg_prescaler
`default_nettype wire

/* File: design/sbg_top.sv */
/*
  sbg_top: serial channel baud generator with synchronous shift engine and APB registers.
  assumes: APB master on the same clock; external shift registers on the data and shift clock pins.
*/
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sbg_top (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe_n,
    output logic shiftClockOut,
    output logic shiftClockOe_n,
    // clocks to the serial channel
    output logic sampleClockTick,
    output logic bitRateTick,
    output logic sampleStrobe,
    output logic asyncRxBit
);
    // =========================================================
    // declarations
    sbg_tick_if tick ();
    logic run_ff;
    logic rateSelect_ff;
    logic fracEnable_ff;
    logic syncMode_ff;
    logic rxEnable_ff;
    logic [sbg_pkg::FDV_W-1:0] fracValue_ff;
    logic [sbg_pkg::TIMER_W-1:0] reload_ff;
    logic [sbg_pkg::TIMER_W-1:0] timer_ff;
    logic pendLoad_ff;
    logic brtTick_ff;
    logic [sbg_pkg::BYTE_W-1:0] txBuf_ff;
    logic txPending_ff;
    logic [sbg_pkg::BYTE_W-1:0] rxBuf_ff;
    logic rxFull_ff;
    logic [3:0] smpCnt_ff;
    logic [1:0] voteOnes_ff;
    sbg_pkg::sbg_state_t state_ff;
    logic [1:0] quarter_ff;
    logic [2:0] bitCnt_ff;
    logic [sbg_pkg::BYTE_W-1:0] shiftReg_ff;
    logic isRx_ff;
    logic dinMeta_ff;
    logic dinSync_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic accessDone;
    logic wrAccess;
    logic rdAccess;
    logic wrBaud;
    logic wrCtrl;
    logic slotEnd;
    logic startRx;
    logic startTx;
    logic byteEnd;
    logic rxDone;
    // =========================================================
    // prescaler
    assign tick.run = run_ff;
    assign tick.rateSelect = rateSelect_ff;
    assign tick.fracEnable = fracEnable_ff;
    assign tick.fracValue = fracValue_ff;
    sbg_prescaler u_prescaler (
        .clock(clock),
        .rstn(rstn),
        .tick(tick.prescaler)
    );
    // =========================================================
    // apb decode
    assign accessDone = psel && penable && pready;
    assign wrAccess = accessDone && pwrite && !nxt_pslverr;
    assign rdAccess = accessDone && !pwrite && !nxt_pslverr;
    assign wrBaud = wrAccess && (paddr == sbg_pkg::ADDR_BAUD);
    assign wrCtrl = wrAccess && (paddr == sbg_pkg::ADDR_CTRL);
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (paddr == sbg_pkg::ADDR_BAUD) begin
            nxt_prdata = {19'h00000, timer_ff};
        end else if (paddr == sbg_pkg::ADDR_CTRL) begin
            nxt_prdata = {27'h0000000, rxEnable_ff, syncMode_ff, fracEnable_ff, rateSelect_ff, run_ff};
        end else if (paddr == sbg_pkg::ADDR_FDV) begin
            nxt_prdata = {23'h000000, fracValue_ff};
        end else if (paddr == sbg_pkg::ADDR_TXD) begin
            nxt_prdata = {24'h000000, txBuf_ff};
        end else if (paddr == sbg_pkg::ADDR_RXD) begin
            nxt_prdata = {24'h000000, rxBuf_ff};
        end else if (paddr == sbg_pkg::ADDR_STAT) begin
            nxt_prdata = {28'h0000000, rxFull_ff, (state_ff != sbg_pkg::SBG_IDLE), 1'b0, txPending_ff};
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // zero-wait answer: ready in the first access cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && nxt_pslverr;
            if (psel && !penable && !pwrite) begin
                prdata <= nxt_prdata;
            end
        end
    end

    // =========================================================
    // control registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 1'b0;
            rateSelect_ff <= 1'b0;
            fracEnable_ff <= 1'b0;
            syncMode_ff <= 1'b0;
            fracValue_ff <= sbg_pkg::FDV_RST;
        end else begin
            if (wrCtrl) begin
                run_ff <= pwdata[sbg_pkg::CTRL_RUN];
                rateSelect_ff <= pwdata[sbg_pkg::CTRL_RSEL];
                fracEnable_ff <= pwdata[sbg_pkg::CTRL_FDE];
                syncMode_ff <= pwdata[sbg_pkg::CTRL_SYNC];
            end
            if (wrAccess && paddr == sbg_pkg::ADDR_FDV) begin
                fracValue_ff <= pwdata[sbg_pkg::FDV_W-1:0];
            end
        end
    end

    // receive enable: software sets, byte completion clears
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxEnable_ff <= 1'b0;
        end else if (wrCtrl) begin
            rxEnable_ff <= pwdata[sbg_pkg::CTRL_RXEN];
        end else if (rxDone) begin
            rxEnable_ff <= 1'b0;
        end
    end

    // =========================================================
    // reload register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reload_ff <= sbg_pkg::TIMER_RST;
        end else if (wrBaud) begin
            reload_ff <= pwdata[sbg_pkg::TIMER_W-1:0];
        end
    end

    // =========================================================
    // baud timer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_ff <= sbg_pkg::TIMER_RST;
            pendLoad_ff <= 1'b0;
            brtTick_ff <= 1'b0;
        end else begin
            brtTick_ff <= 1'b0;
            if (wrBaud) begin
                if (run_ff) begin
                    timer_ff <= pwdata[sbg_pkg::TIMER_W-1:0];
                end
                pendLoad_ff <= !run_ff;
            end else if (run_ff && pendLoad_ff) begin
                timer_ff <= reload_ff;
                pendLoad_ff <= 1'b0;
            end else if (run_ff && tick.divTick) begin
                if (timer_ff == sbg_pkg::TIMER_RST) begin
                    timer_ff <= reload_ff;
                    brtTick_ff <= 1'b1;
                end else begin
                    timer_ff <= timer_ff - 13'h0001;
                end
            end
        end
    end

    // =========================================================
    // asynchronous sample and bit rate clocks
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            smpCnt_ff <= 4'h0;
            voteOnes_ff <= 2'h0;
            sampleClockTick <= 1'b0;
            bitRateTick <= 1'b0;
            sampleStrobe <= 1'b0;
            asyncRxBit <= 1'b1;
        end else begin
            sampleClockTick <= brtTick_ff && !syncMode_ff;
            bitRateTick <= brtTick_ff && !syncMode_ff && (smpCnt_ff == sbg_pkg::SMP_LAST);
            sampleStrobe <= brtTick_ff && !syncMode_ff && (smpCnt_ff >= sbg_pkg::SMP_FIRST_VOTE)
                && (smpCnt_ff <= sbg_pkg::SMP_LAST_VOTE);
            if (syncMode_ff) begin
                smpCnt_ff <= 4'h0;
                voteOnes_ff <= 2'h0;
            end else if (brtTick_ff) begin
                smpCnt_ff <= smpCnt_ff + 4'h1;
                if (smpCnt_ff == sbg_pkg::SMP_FIRST_VOTE) begin
                    voteOnes_ff <= {1'b0, dinSync_ff};
                end else if (smpCnt_ff > sbg_pkg::SMP_FIRST_VOTE && smpCnt_ff < sbg_pkg::SMP_LAST_VOTE) begin
                    voteOnes_ff <= voteOnes_ff + {1'b0, dinSync_ff};
                end else if (smpCnt_ff == sbg_pkg::SMP_LAST_VOTE) begin
                    asyncRxBit <= (voteOnes_ff + {1'b0, dinSync_ff}) >= 2'h2;
                end
            end
        end
    end

    // =========================================================
    // data pin synchroniser
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dinMeta_ff <= 1'b1;
            dinSync_ff <= 1'b1;
        end else begin
            dinMeta_ff <= serialDataIn;
            dinSync_ff <= dinMeta_ff;
        end
    end

    // =========================================================
    // transmit buffer and receive status
    assign slotEnd = brtTick_ff && ((state_ff == sbg_pkg::SBG_IDLE)
        || (state_ff == sbg_pkg::SBG_GAP && quarter_ff == sbg_pkg::Q_LAST));
    assign startRx = slotEnd && syncMode_ff && run_ff && rxEnable_ff;
    assign startTx = slotEnd && syncMode_ff && run_ff && !rxEnable_ff && txPending_ff;
    assign byteEnd = brtTick_ff && (state_ff == sbg_pkg::SBG_SHIFT) && (quarter_ff == sbg_pkg::Q_LAST)
        && (bitCnt_ff == sbg_pkg::BIT_LAST);
    assign rxDone = byteEnd && isRx_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txBuf_ff <= sbg_pkg::BYTE_RST;
            txPending_ff <= 1'b0;
        end else begin
            if (wrAccess && paddr == sbg_pkg::ADDR_TXD) begin
                txBuf_ff <= pwdata[sbg_pkg::BYTE_W-1:0];
                txPending_ff <= 1'b1;
            end else if (startTx) begin
                txPending_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxFull_ff <= 1'b0;
        end else if (rxDone) begin
            rxFull_ff <= 1'b1;
        end else if (rdAccess && paddr == sbg_pkg::ADDR_RXD) begin
            rxFull_ff <= 1'b0;
        end
    end

    // =========================================================
    // synchronous shift engine, four timer ticks per shift period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= sbg_pkg::SBG_IDLE;
            quarter_ff <= 2'h0;
            bitCnt_ff <= 3'h0;
            shiftReg_ff <= sbg_pkg::BYTE_RST;
            isRx_ff <= 1'b0;
            rxBuf_ff <= sbg_pkg::BYTE_RST;
            shiftClockOut <= 1'b1;
            serialDataOut <= 1'b1;
        end else if (!syncMode_ff) begin
            state_ff <= sbg_pkg::SBG_IDLE;
            quarter_ff <= 2'h0;
            shiftClockOut <= 1'b1;
            serialDataOut <= 1'b1;
        end else if (startRx || startTx) begin
            state_ff <= sbg_pkg::SBG_SHIFT;
            quarter_ff <= 2'h0;
            bitCnt_ff <= 3'h0;
            isRx_ff <= startRx;
            shiftClockOut <= 1'b0;
            if (startTx) begin
                shiftReg_ff <= txBuf_ff;
                serialDataOut <= txBuf_ff[0];
            end
        end else if (brtTick_ff && state_ff != sbg_pkg::SBG_IDLE) begin
            quarter_ff <= quarter_ff + 2'h1;
            case (state_ff)
                sbg_pkg::SBG_SHIFT: begin
                    if (quarter_ff == sbg_pkg::Q_BEFORE_RISE) begin
                        shiftClockOut <= 1'b1;
                        if (isRx_ff) begin
                            shiftReg_ff <= {dinSync_ff, shiftReg_ff[sbg_pkg::BYTE_W-1:1]};
                        end
                    end else if (quarter_ff == sbg_pkg::Q_LAST) begin
                        if (bitCnt_ff == sbg_pkg::BIT_LAST) begin
                            state_ff <= sbg_pkg::SBG_GAP;
                            serialDataOut <= 1'b1;
                            if (isRx_ff) begin
                                rxBuf_ff <= shiftReg_ff;
                            end
                        end else begin
                            bitCnt_ff <= bitCnt_ff + 3'h1;
                            shiftClockOut <= 1'b0;
                            if (!isRx_ff) begin
                                serialDataOut <= shiftReg_ff[1];
                                shiftReg_ff <= {1'b0, shiftReg_ff[sbg_pkg::BYTE_W-1:1]};
                            end
                        end
                    end
                end
                sbg_pkg::SBG_GAP: begin
                    shiftClockOut <= 1'b1;
                    if (quarter_ff == sbg_pkg::Q_LAST) begin
                        state_ff <= sbg_pkg::SBG_IDLE;
                    end
                end
                default: begin
                    shiftClockOut <= 1'b1;
                end
            endcase
        end
    end

    // =========================================================
    // pin drive enables
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serialDataOe_n <= 1'b1;
            shiftClockOe_n <= 1'b1;
        end else begin
            serialDataOe_n <= !(syncMode_ff && !rxEnable_ff && !(state_ff == sbg_pkg::SBG_SHIFT && isRx_ff));
            shiftClockOe_n <= !syncMode_ff;
        end
    end
endmodule // sbg_top
`default_nettype wire

/* File: test/sbg_top_assertions.sv */
/* sbg_top_assertions: port timing checks of sbg_top.
   assumes: bound to sbg_top, single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sbg_top_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // pins and ticks
    input wire logic serialDataOut,
    input wire logic serialDataOe_n,
    input wire logic shiftClockOut,
    input wire logic shiftClockOe_n,
    input wire logic sampleClockTick,
    input wire logic bitRateTick,
    input wire logic sampleStrobe
);
    // ==========
    // sample ticks since the last bit rate tick
    logic [3:0] smpCnt_ff;
    logic smpSeen_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            smpCnt_ff <= 4'h0;
            smpSeen_ff <= 1'b0;
        end else if (bitRateTick) begin
            smpCnt_ff <= 4'h0;
            smpSeen_ff <= 1'b1;
        end else if (sampleClockTick) begin
            smpCnt_ff <= smpCnt_ff + 4'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        pready ##1 !pready;
    endsequence
    // ==========
    // properties
    apb_ready_a: assert property (setup_s |=> access_s)
        else $error("pready not in first access cycle");
    apb_error_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_clock_a: assert property (shiftClockOe_n |-> shiftClockOut)
        else $error("shift clock low while idle");
    data_on_fall_a: assert property (!serialDataOe_n && !$past(serialDataOe_n) && $changed(serialDataOut)
        |-> $fell(shiftClockOut) || (serialDataOut && shiftClockOut))
        else $error("data changed off a falling shift clock");
    sync_quiet_a: assert property (!shiftClockOe_n && !$past(shiftClockOe_n)
        |-> !sampleClockTick && !bitRateTick)
        else $error("async ticks in sync mode");
    strobe_tick_a: assert property (sampleStrobe |-> sampleClockTick)
        else $error("strobe off a sample tick");
    bit_rate_a: assert property (bitRateTick |-> sampleClockTick
        && (!smpSeen_ff || smpCnt_ff == sbg_pkg::SMP_LAST))
        else $error("bit rate tick not every 16th sample");
    vote_window_a: assert property (sampleStrobe && smpSeen_ff
        |-> smpCnt_ff >= sbg_pkg::SMP_FIRST_VOTE && smpCnt_ff <= sbg_pkg::SMP_LAST_VOTE)
        else $error("strobe outside 7th to 9th sample");
endmodule // sbg_top_assertions
bind sbg_top sbg_top_assertions sbg_top_assertions_inst (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .serialDataOut(serialDataOut),
    .serialDataOe_n(serialDataOe_n), .shiftClockOut(shiftClockOut), .shiftClockOe_n(shiftClockOe_n),
    .sampleClockTick(sampleClockTick), .bitRateTick(bitRateTick), .sampleStrobe(sampleStrobe));
`default_nettype wire

/* File: test/sbg_shift_partner.sv */
/* sbg_shift_partner: external shift register on data and shift clock pins.
   assumes: the bench resolves the data pin level. */
`timescale 1ns/1ps
`default_nettype none
module sbg_shift_partner (
    // clock
    input wire logic clock,
    // pins
    input wire logic shiftClock,
    input wire logic dataPin,
    output logic dataOut,
    // byte to send and byte seen
    input wire logic [7:0] sendByte,
    output logic [7:0] gotByte
);
    int bitCnt = 0;
    bit inFrame = 1'b0;
    initial dataOut = 1'b1;
    initial gotByte = 8'h00;
    // next bit out on the falling shift clock
    always @(negedge shiftClock) begin
        inFrame = 1'b1;
        dataOut <= sendByte[bitCnt];
    end
    // capture on the rising shift clock, lsb first
    always @(posedge shiftClock) begin
        if (inFrame) begin
            gotByte <= {dataPin, gotByte[7:1]};
            bitCnt = (bitCnt + 1) % 8;
            if (bitCnt == 0) inFrame = 1'b0;
        end
    end
    // outside frames the line carries no stable value
    always @(posedge clock) begin
        if (!inFrame) dataOut <= ~dataOut;
    end
endmodule // sbg_shift_partner
`default_nettype wire

/* File: test/sbg_tb_top.sv */
/* sbg_tb_top: self-checking bench for the baud generator.
   assumes: partner model on the pins, checker bound to sbg_top. */
`timescale 1ns/1ps
`default_nettype none
module sbg_tb_top;
    // ==========
    // signals
    logic clock;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire logic dataPin;
    logic partnerOut;
    logic serialDataOut;
    logic serialDataOe_n;
    logic shiftClockOut;
    logic shiftClockOe_n;
    logic sampleClockTick;
    logic bitRateTick;
    logic sampleStrobe;
    logic asyncRxBit;
    logic [7:0] sendByte;
    logic [7:0] gotByte;
    logic [31:0] rdData;
    logic errBit;
    int errTotal = 0;
    int checksDone = 0;
    assign dataPin = serialDataOe_n ? partnerOut : serialDataOut;
    sbg_top sbg_top_inst (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialDataIn(dataPin), .serialDataOut(serialDataOut), .serialDataOe_n(serialDataOe_n),
        .shiftClockOut(shiftClockOut), .shiftClockOe_n(shiftClockOe_n), .sampleClockTick(sampleClockTick),
        .bitRateTick(bitRateTick), .sampleStrobe(sampleStrobe), .asyncRxBit(asyncRxBit));
    sbg_shift_partner sbg_shift_partner_inst (.clock(clock), .shiftClock(shiftClockOut), .dataPin(dataPin),
        .dataOut(partnerOut), .sendByte(sendByte), .gotByte(gotByte));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ==========
    // shared tasks
    task automatic giveVerdict();
        if (errTotal == 0 && checksDone > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic timedOut();
        errTotal++;
        giveVerdict();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic resetDut();
        rstn <= 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdData = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 20) timedOut();
    endtask
    task automatic tickGap(input logic useBit, output int cyc);
        int n;
        n = 0;
        while ((useBit ? bitRateTick : sampleClockTick) !== 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        cyc = 0;
        do begin
            @(posedge clock);
            cyc++;
        end while ((useBit ? bitRateTick : sampleClockTick) !== 1'b1 && cyc < 1000);
        if (n >= 1000 || cyc >= 1000) timedOut();
    endtask
    // ==========
    // scenarios
    task automatic test_reset();
        logic [7:0] regs [3] = '{sbg_pkg::ADDR_BAUD, sbg_pkg::ADDR_CTRL, sbg_pkg::ADDR_FDV};
        resetDut();
        for (int i = 0; i < 3; i++) begin
            xfer(regs[i], 1'b0, 32'h0);
            check(rdData, 32'h0);
        end
        xfer(8'h3C, 1'b0, 32'h0);
        check({errBit, rdData[30:0]}, 32'h80000000);
        check({31'h0, shiftClockOut}, 32'h1);
    endtask
    task automatic test_timer();
        logic [31:0] held;
        resetDut();
        xfer(sbg_pkg::ADDR_BAUD, 1'b1, 32'hFFFFF005);
        xfer(sbg_pkg::ADDR_BAUD, 1'b0, 32'h0);
        check(rdData, 32'h0);
        xfer(sbg_pkg::ADDR_CTRL, 1'b1, 32'h1);
        xfer(sbg_pkg::ADDR_BAUD, 1'b0, 32'h0);
        check({31'h0, rdData <= 32'h1005 && rdData >= 32'h1000}, 32'h1);
        xfer(sbg_pkg::ADDR_CTRL, 1'b1, 32'h0);
        xfer(sbg_pkg::ADDR_BAUD, 1'b0, 32'h0);
        held = rdData;
        xfer(sbg_pkg::ADDR_BAUD, 1'b0, 32'h0);
        check(rdData, held);
    endtask
    task automatic test_rates();
        logic [31:0] rld [5] = '{32'h2, 32'h2, 32'h2, 32'h0, 32'h1};
        logic [31:0] fdv [5] = '{32'h0, 32'h0, 32'h0, 32'h100, 32'h0};
        logic [31:0] ctl [5] = '{32'h1, 32'h3, 32'h5, 32'h5, 32'h7};
        int per [5] = '{6, 9, 3, 2, 2};
        int cyc;
        for (int i = 0; i < 5; i++) begin
            resetDut();
            xfer(sbg_pkg::ADDR_BAUD, 1'b1, rld[i]);
            xfer(sbg_pkg::ADDR_FDV, 1'b1, fdv[i]);
            xfer(sbg_pkg::ADDR_CTRL, 1'b1, ctl[i]);
            tickGap(1'b0, cyc);
            check(cyc, per[i]);
            tickGap(1'b1, cyc);
            check(cyc, 16 * per[i]);
        end
    endtask
    task automatic test_sync_tx();
        int falls;
        int hiLen;
        int n;
        int k;
        logic prevClk;
        resetDut();
        xfer(sbg_pkg::ADDR_BAUD, 1'b1, 32'h1);
        xfer(sbg_pkg::ADDR_CTRL, 1'b1, 32'h9);
        falls = 0;
        hiLen = 0;
        n = 0;
        k = 0;
        prevClk = 1'b1;
        fork
            begin
                xfer(sbg_pkg::ADDR_TXD, 1'b1, 32'hA5);
                do begin
                    xfer(sbg_pkg::ADDR_STAT, 1'b0, 32'h0);
                    k++;
                end while (rdData[0] !== 1'b0 && k < 50);
                xfer(sbg_pkg::ADDR_TXD, 1'b1, 32'h3C);
            end
            while (falls < 16 && n < 3000) begin
                @(posedge clock);
                n++;
                if (!shiftClockOut && prevClk) begin
                    falls++;
                    if (falls == 9) begin
                        check(hiLen, 24);
                        check({24'h0, gotByte}, 32'hA5);
                    end
                    hiLen = 0;
                end
                if (shiftClockOut) hiLen++;
                prevClk = shiftClockOut;
            end
        join
        while (gotByte !== 8'h3C && n < 3200) begin
            @(posedge clock);
            n++;
        end
        check({24'h0, gotByte}, 32'h3C);
        if (n >= 3000 || k >= 50) timedOut();
    endtask
    task automatic test_sync_rx();
        int k;
        k = 0;
        resetDut();
        sendByte <= 8'h5A;
        xfer(sbg_pkg::ADDR_BAUD, 1'b1, 32'h1);
        xfer(sbg_pkg::ADDR_CTRL, 1'b1, 32'h19);
        do begin
            xfer(sbg_pkg::ADDR_CTRL, 1'b0, 32'h0);
            k++;
        end while (rdData[4] !== 1'b0 && k < 200);
        if (k >= 200) timedOut();
        xfer(sbg_pkg::ADDR_RXD, 1'b0, 32'h0);
        check(rdData, 32'h5A);
        check({29'h0, asyncRxBit, shiftClockOe_n, serialDataOe_n}, 32'h4);
        check({31'h0, shiftClockOut}, 32'h1);
    endtask
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sendByte = 8'hFF;
        test_reset();
        test_timer();
        test_rates();
        test_sync_tx();
        test_sync_rx();
        giveVerdict();
    end
endmodule // sbg_tb_top
`default_nettype wire
